// ==== include/rhp_pkg.sv ====
// package: constants and carrier types for the port 2 change register block
package rhp_pkg;

    // local byte address width seen by this slave
    localparam int RHP_ADDR_W = 8;

    // register byte offsets
    localparam logic [RHP_ADDR_W-1:0] RHP_OFS_PORT = 8'h00;
    localparam logic [RHP_ADDR_W-1:0] RHP_OFS_IRQ_STAT = 8'h04;
    localparam logic [RHP_ADDR_W-1:0] RHP_OFS_IRQ_MASK = 8'h08;
    localparam logic [RHP_ADDR_W-1:0] RHP_OFS_DESC_B = 8'h0C;

    // port status and control bit positions
    localparam int RHP_B_RESET_CHANGE_FLAG = 20;
    localparam int RHP_B_OVERCURRENT_CHANGE_FLAG = 19;
    localparam int RHP_B_SUSPEND_CHANGE_FLAG = 18;
    localparam int RHP_B_ENABLE_CHANGE_FLAG = 17;
    localparam int RHP_B_CSC = 16;
    localparam int RHP_B_LOW_SPEED_ATTACHED = 9;
    localparam int RHP_B_PWR = 8;
    localparam int RHP_B_PRS = 4;
    localparam int RHP_B_POCI = 3;
    localparam int RHP_B_PSS = 2;
    localparam int RHP_B_PES = 1;
    localparam int RHP_B_CCS = 0;

    // descriptor b: nonremovable bit of port 2
    localparam int RHP_B_DR2 = 2;

    // interrupt status and mask layout
    localparam int RHP_IRQ_W = 4;
    localparam int RHP_I_CSC = 0;
    localparam int RHP_I_ENABLE_CHANGE_FLAG = 1;
    localparam int RHP_I_SUSPEND_CHANGE_FLAG = 2;
    localparam int RHP_I_RESET_CHANGE_FLAG = 3;

    // ahb constants
    localparam logic [2:0] RHP_HSIZE_WORD = 3'h2;

    // reset values
    localparam logic RHP_RST_PWR = 1'b1;
    localparam logic [RHP_IRQ_W-1:0] RHP_RST_MASK = 4'h0;
    localparam logic RHP_RST_DR2 = 1'b0;

    // timing: resume synchronisation delay
    localparam int RHP_CLK_HZ = 100_000_000;
    localparam int RHP_SYNC_DELAY_MS = 3;
    localparam int RHP_SYNC_CYCLES = RHP_SYNC_DELAY_MS * (RHP_CLK_HZ / 1000);

    // suspend change tracker states
    typedef enum logic [1:0] {
        RHP_SUS_IDLE = 2'b00,
        RHP_SUS_WAIT_EOP = 2'b01,
        RHP_SUS_SYNC = 2'b10
    } rhp_sus_t;

    // status coming from the lower port logic
    typedef struct packed {
        logic current_connect_status;
        logic port_reset_status;
        logic pes;
        logic pss;
        logic low_speed_attached;
        logic eop_done;
        logic hub_reset;
    } rhp_port_in_t;

    // one-cycle commands to the lower port logic
    typedef struct packed {
        logic set_reset;
        logic set_enable;
        logic set_suspend;
    } rhp_cmd_t;

    // whole state of the register block
    typedef struct packed {
        rhp_port_in_t prev;
        logic reset_change_flag;
        logic suspend_change_flag;
        logic enable_change_flag;
        logic connect_change_flag;
        logic pwr;
        logic [RHP_IRQ_W-1:0] irq_stat;
        logic [RHP_IRQ_W-1:0] irq_mask;
        logic dr2;
        rhp_sus_t sus;
        logic tmr_start;
        logic wr_pend;
        logic [RHP_ADDR_W-1:0] wr_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        rhp_cmd_t cmd;
        logic irq;
    } rhp_state_t;

    localparam rhp_state_t RHP_ST_RST = '{
        pwr: RHP_RST_PWR,
        irq_mask: RHP_RST_MASK,
        dr2: RHP_RST_DR2,
        sus: RHP_SUS_IDLE,
        hreadyout: 1'b1,
        default: '0
    };

endpackage

// ==== logic/rhp_sync_timer.sv ====
// resume synchronisation delay timer for the port 2 change block
`timescale 1ns/10ps
module rhp_sync_timer
    import rhp_pkg::*;
#(
    parameter int CYCLES = RHP_SYNC_CYCLES
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    output logic done
);

    // counter width follows the delay length
    localparam int CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES - 1);

    // all timer state
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic busy;
        logic done;
    } rhp_tmr_t;

    rhp_tmr_t st;
    rhp_tmr_t next_st;

    // refuse a delay the counter cannot serve
    if (CYCLES < 1)
    begin : g_chk
        $error("rhp_sync_timer: CYCLES must be at least one");
    end

    // done pulses exactly CYCLES+1 edges after start
    always_comb
    begin
        next_st = st;
        next_st.done = 1'b0;
        if (start)
        begin
            // a fresh start restarts the count
            next_st.busy = 1'b1;
            next_st.cnt = LOAD;
        end
        else if (st.busy)
        begin
            if (st.cnt == '0)
            begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end
            else
            begin
                next_st.cnt = st.cnt - 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign done = st.done;

endmodule

// ==== logic/rhp_port2_change.sv ====
// port 2 status change register bank with ahb-lite slave and interrupt
`timescale 1ns/10ps
// Operation
// R1: reset status change sets bit 20, w1c
// R2: bit 19 always reads zero
// R3: suspend status change sets bit 18, w1c
// R4: suspend change waits resume, eop, 3 ms
// R5: enable status change sets bit 17, w1c
// R6: connect or disconnect sets bit 16, w1c
// R7: nonremovable port: connect change after hub reset
// R8: set command while disconnected sets bit 16
// R9: bit 9 reads low-speed device attached
// R10: software trusts bit 9 only when connected
// R11: writing one to bit 9 clears power
// R12: writing zero to bit 9 changes nothing
// R13: power bits drive no external pin
// R14: writing one to bit 4 starts reset
// R15: writing one to bit 8 sets power
// R16: reserved bits read zero, ignore writes
module rhp_port2_change
    import rhp_pkg::*;
#(
    parameter int SYNC_CYCLES = RHP_SYNC_CYCLES
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [RHP_ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire rhp_port_in_t port_in,
    output rhp_cmd_t port_cmd,
    output logic irq
);

    // the whole block state and its next value
    rhp_state_t st;
    rhp_state_t next_st;

    // timer handshake
    logic tmr_done;

    // events of this cycle, interrupt layout
    logic [RHP_IRQ_W-1:0] ev;

    // address phase accepted this cycle
    logic take;

    // decoded data-phase write to the port register
    logic wr_port;

    // refuse a zero synchronisation delay
    if (SYNC_CYCLES < 1)
    begin : g_chk
        $error("rhp_port2_change: SYNC_CYCLES must be at least one");
    end

    // resume synchronisation delay
    rhp_sync_timer #(
        .CYCLES(SYNC_CYCLES)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(st.tmr_start),
        .done(tmr_done)
    );

    // read word of a register, built from a given state
    function automatic logic [31:0] read_word(input rhp_state_t s, input logic [RHP_ADDR_W-1:0] a);
        logic [31:0] w;
        w = '0;
        case (a)
            RHP_OFS_PORT:
            begin
                // reserved and overcurrent bits stay zero
                w[RHP_B_RESET_CHANGE_FLAG] = s.reset_change_flag;
                w[RHP_B_OVERCURRENT_CHANGE_FLAG] = 1'b0; // R2
                w[RHP_B_SUSPEND_CHANGE_FLAG] = s.suspend_change_flag;
                w[RHP_B_ENABLE_CHANGE_FLAG] = s.enable_change_flag;
                w[RHP_B_CSC] = s.connect_change_flag;
                w[RHP_B_LOW_SPEED_ATTACHED] = s.prev.low_speed_attached; // R9
                w[RHP_B_PWR] = s.pwr;
                w[RHP_B_PRS] = s.prev.port_reset_status;
                w[RHP_B_POCI] = 1'b0;
                w[RHP_B_PSS] = s.prev.pss;
                w[RHP_B_PES] = s.prev.pes;
                w[RHP_B_CCS] = s.prev.current_connect_status;
            end
            RHP_OFS_IRQ_STAT:
            begin
                w[RHP_IRQ_W-1:0] = s.irq_stat;
            end
            RHP_OFS_IRQ_MASK:
            begin
                w[RHP_IRQ_W-1:0] = s.irq_mask;
            end
            RHP_OFS_DESC_B:
            begin
                w[RHP_B_DR2] = s.dr2;
            end
            default:
            begin
                // unmapped offsets read zero
                w = '0;
            end
        endcase
        return w; // R16
    endfunction

    // only whole-word transfers are taken; others are ignored with okay
    assign take = hsel && htrans[1] && hready && (hsize == RHP_HSIZE_WORD);
    assign wr_port = st.wr_pend && (st.wr_addr == RHP_OFS_PORT);

    // next-state logic for bus, flags, power and interrupt
    always_comb
    begin
        next_st = st;
        next_st.cmd = '0;
        next_st.tmr_start = 1'b0;
        next_st.hreadyout = 1'b1;
        next_st.hresp = 1'b0;
        ev = '0;

        // status edges from the lower port logic
        if (port_in.port_reset_status != st.prev.port_reset_status)
        begin
            ev[RHP_I_RESET_CHANGE_FLAG] = 1'b1; // R1
        end
        if (port_in.pes != st.prev.pes)
        begin
            ev[RHP_I_ENABLE_CHANGE_FLAG] = 1'b1; // R5
        end
        if (!st.dr2 && (port_in.current_connect_status != st.prev.current_connect_status))
        begin
            ev[RHP_I_CSC] = 1'b1; // R6
        end
        // nonremovable device is reported once per hub reset
        if (st.dr2 && port_in.hub_reset && port_in.current_connect_status)
        begin
            ev[RHP_I_CSC] = 1'b1; // R7
        end

        // suspend change: entry is immediate, exit waits resume and sync
        case (st.sus)
            RHP_SUS_IDLE:
            begin
                if (port_in.pss && !st.prev.pss)
                begin
                    ev[RHP_I_SUSPEND_CHANGE_FLAG] = 1'b1; // R3
                end
                else if (!port_in.pss && st.prev.pss)
                begin
                    next_st.sus = RHP_SUS_WAIT_EOP; // R4
                end
            end
            RHP_SUS_WAIT_EOP:
            begin
                // resume pulse and low-speed eop still running
                if (port_in.eop_done)
                begin
                    next_st.sus = RHP_SUS_SYNC;
                    next_st.tmr_start = 1'b1; // R4
                end
            end
            RHP_SUS_SYNC:
            begin
                if (tmr_done)
                begin
                    next_st.sus = RHP_SUS_IDLE;
                    ev[RHP_I_SUSPEND_CHANGE_FLAG] = 1'b1; // R4
                end
            end
            default:
            begin
                next_st.sus = RHP_SUS_IDLE;
            end
        endcase

        // set commands while disconnected only raise the connect change
        if (wr_port && (hwdata[RHP_B_PRS] || hwdata[RHP_B_PES] || hwdata[RHP_B_PSS]))
        begin
            if (port_in.current_connect_status)
            begin
                next_st.cmd.set_reset = hwdata[RHP_B_PRS]; // R14
                next_st.cmd.set_enable = hwdata[RHP_B_PES];
                next_st.cmd.set_suspend = hwdata[RHP_B_PSS];
            end
            else
            begin
                ev[RHP_I_CSC] = 1'b1; // R8
            end
        end

        // change flags: a set in the clear cycle wins
        next_st.reset_change_flag = (st.reset_change_flag & ~(wr_port & hwdata[RHP_B_RESET_CHANGE_FLAG])) | ev[RHP_I_RESET_CHANGE_FLAG]; // R1
        next_st.suspend_change_flag = (st.suspend_change_flag & ~(wr_port & hwdata[RHP_B_SUSPEND_CHANGE_FLAG])) | ev[RHP_I_SUSPEND_CHANGE_FLAG]; // R3
        next_st.enable_change_flag = (st.enable_change_flag & ~(wr_port & hwdata[RHP_B_ENABLE_CHANGE_FLAG])) | ev[RHP_I_ENABLE_CHANGE_FLAG]; // R5
        next_st.connect_change_flag = (st.connect_change_flag & ~(wr_port & hwdata[RHP_B_CSC])) | ev[RHP_I_CSC]; // R6

        // power status is bookkeeping only, never a pin
        if (wr_port && hwdata[RHP_B_LOW_SPEED_ATTACHED])
        begin
            // clear beats a simultaneous set
            next_st.pwr = 1'b0; // R11
        end
        else if (wr_port && hwdata[RHP_B_PWR])
        begin
            next_st.pwr = 1'b1; // R15
        end
        // a zero in bit 9 leaves power and low-speed alone: R12, R13

        // interrupt status: sticky, write one to clear, set wins
        if (st.wr_pend && (st.wr_addr == RHP_OFS_IRQ_STAT))
        begin
            next_st.irq_stat = (st.irq_stat & ~hwdata[RHP_IRQ_W-1:0]) | ev;
        end
        else
        begin
            next_st.irq_stat = st.irq_stat | ev;
        end

        // plain read/write configuration registers
        if (st.wr_pend && (st.wr_addr == RHP_OFS_IRQ_MASK))
        begin
            next_st.irq_mask = hwdata[RHP_IRQ_W-1:0];
        end
        if (st.wr_pend && (st.wr_addr == RHP_OFS_DESC_B))
        begin
            next_st.dr2 = hwdata[RHP_B_DR2];
        end

        // sample port status for edges and read-back
        next_st.prev = port_in;

        // address phase; read data is built from the updated state so that
        // a read right behind a write sees the written value
        next_st.wr_pend = take && hwrite;
        next_st.wr_addr = haddr;
        if (take && !hwrite)
        begin
            next_st.hrdata = read_word(next_st, haddr);
        end
        else
        begin
            next_st.hrdata = '0;
        end

        // level interrupt from unmasked sticky bits
        next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
    end

    // single state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st <= RHP_ST_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign hrdata = st.hrdata;
    assign hreadyout = st.hreadyout;
    assign hresp = st.hresp;
    assign port_cmd = st.cmd;
    assign irq = st.irq;

    // checks on the block's own behaviour
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_OVERCURRENT_CHANGE_FLAG_ZERO: assert property (hrdata[RHP_B_OVERCURRENT_CHANGE_FLAG] == 1'b0) // R2
        else $error("overcurrent change bit read as one");

    AST_RSV_ZERO: assert property (hrdata[31:21] == '0 && hrdata[15:10] == '0) // R16
        else $error("reserved bits read nonzero");

    AST_RESET_CHANGE_FLAG_SET: assert property ((port_in.port_reset_status != st.prev.port_reset_status) |=> st.reset_change_flag ##1 st.irq_stat[RHP_I_RESET_CHANGE_FLAG]) // R1
        else $error("reset change not flagged");

    AST_CSC_W1C: assert property ((wr_port && hwdata[RHP_B_CSC] && !ev[RHP_I_CSC]) |=> !st.connect_change_flag) // R6
        else $error("connect change not cleared by write one");

    AST_SUSPEND_CHANGE_FLAG_WAIT: assert property ((st.sus == RHP_SUS_WAIT_EOP) |-> !ev[RHP_I_SUSPEND_CHANGE_FLAG]) // R4
        else $error("suspend change raised before resume end");

    AST_SUSPEND_CHANGE_FLAG_DONE: assert property ((st.sus == RHP_SUS_SYNC && tmr_done) |=> st.suspend_change_flag && st.sus == RHP_SUS_IDLE) // R4
        else $error("suspend change missing after sync delay");

    AST_CSC_DISC: assert property ((wr_port && hwdata[RHP_B_PRS] && !port_in.current_connect_status) |=> st.connect_change_flag && !port_cmd.set_reset) // R8
        else $error("set command while disconnected mishandled");

    AST_CSC_DR: assert property ((st.dr2 && !st.connect_change_flag && !port_in.hub_reset && !wr_port) |=> !st.connect_change_flag) // R7
        else $error("nonremovable port flagged without hub reset");

    AST_PWR_CLR: assert property ((wr_port && hwdata[RHP_B_LOW_SPEED_ATTACHED]) |=> !st.pwr) // R11
        else $error("power not cleared");

    AST_PWR_SET: assert property ((wr_port && hwdata[RHP_B_PWR] && !hwdata[RHP_B_LOW_SPEED_ATTACHED]) |=> st.pwr) // R15
        else $error("power not set");

    AST_PWR_HOLD: assert property ((wr_port && !hwdata[RHP_B_LOW_SPEED_ATTACHED] && !hwdata[RHP_B_PWR]) |=> $stable(st.pwr)) // R12
        else $error("power changed by a zero write");

    AST_RST_CMD: assert property ((wr_port && hwdata[RHP_B_PRS] && port_in.current_connect_status) |=> port_cmd.set_reset ##1 !port_cmd.set_reset) // R14
        else $error("reset command not a single pulse");

    AST_LOW_SPEED_ATTACHED_RD: assert property ((take && !hwrite && haddr == RHP_OFS_PORT) |=> hrdata[RHP_B_LOW_SPEED_ATTACHED] == $past(port_in.low_speed_attached)) // R9
        else $error("low-speed bit read wrong");

    // main scenarios
    COV_CSC_DISC: cover property (wr_port && !port_in.current_connect_status ##1 st.connect_change_flag);
    COV_SUSPEND_CHANGE_FLAG_SYNC: cover property (st.sus == RHP_SUS_SYNC && tmr_done);
    COV_IRQ: cover property (!irq ##1 irq);
    COV_PWR_CLR: cover property (st.pwr ##1 !st.pwr);

endmodule

// ==== tb/rhp_usb_dev.sv ====
// model of the attached device and lower port logic feeding port 2 status
`timescale 1ns/10ps
module rhp_usb_dev
    import rhp_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic attach, // device plugged in
    input wire logic low_speed, // device is low speed
    input wire logic resume, // one-cycle resume request
    input wire logic hub_rst, // one-cycle root hub reset
    input wire rhp_cmd_t port_cmd,
    output rhp_port_in_t port_in
);
    logic [3:0] rst_cnt; // length of reset signalling
    logic [3:0] eop_cnt; // resume pulse plus low-speed eop

    // port reacts to commands one edge later, like the real lower logic
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            port_in <= '0;
            rst_cnt <= 4'h0;
            eop_cnt <= 4'h0;
        end
        else
        begin
            port_in.current_connect_status <= attach;
            // speed line is forced low while detached, software must not trust it
            port_in.low_speed_attached <= attach & low_speed;
            port_in.hub_reset <= hub_rst;
            port_in.eop_done <= (eop_cnt == 4'h1);
            eop_cnt <= (eop_cnt != 4'h0) ? eop_cnt - 4'h1 : 4'h0;
            if (!attach)
            begin
                // unplug drops enable and suspend
                port_in.pes <= 1'b0;
                port_in.pss <= 1'b0;
            end
            else if (port_cmd.set_reset)
            begin
                port_in.port_reset_status <= 1'b1;
                rst_cnt <= 4'h8;
            end
            else if (rst_cnt != 4'h0)
            begin
                rst_cnt <= rst_cnt - 4'h1;
                if (rst_cnt == 4'h1)
                begin
                    // end of reset enables the port
                    port_in.port_reset_status <= 1'b0;
                    port_in.pes <= 1'b1;
                end
            end
            else if (port_cmd.set_enable)
                port_in.pes <= 1'b1;
            else if (port_cmd.set_suspend)
                port_in.pss <= 1'b1;
            else if (resume && port_in.pss)
            begin
                // leave suspend, eop follows a few cycles later
                port_in.pss <= 1'b0;
                eop_cnt <= 4'h4;
            end
        end
    end
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the port 2 change register block
`timescale 1ns/10ps
module tb
    import rhp_pkg::*;
;
    logic hclk; // 100 MHz bus clock
    logic hresetn; // active low reset
    logic hsel;
    logic [RHP_ADDR_W-1:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    rhp_port_in_t port_in;
    rhp_cmd_t port_cmd;
    logic irq;
    logic attach, low_speed, resume, hub_rst; // device model controls
    int mismatches; // failed compares
    int num_checks; // compares made
    int ncmd; // command pulses seen
    logic [31:0] rd;
    logic [31:0] cmds [3];

    rhp_port2_change #(.SYNC_CYCLES(20)) rhp_port2_change_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .port_in(port_in), .port_cmd(port_cmd), .irq(irq));

    rhp_usb_dev rhp_usb_dev_i (
        .hclk(hclk), .hresetn(hresetn), .attach(attach), .low_speed(low_speed),
        .resume(resume), .hub_rst(hub_rst), .port_cmd(port_cmd), .port_in(port_in));

    // free-running clock
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // count command pulses towards the port
    always @(posedge hclk)
        if (port_cmd != 3'h0)
            ncmd++;

    // compare and report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one ahb-lite transfer: address phase, then data phase
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // one-cycle pulse on a model control: 0 resume, 1 hub reset
    // a select keeps the drive on module variables, not on a ref alias
    task automatic pulse(input bit sel);
        @(posedge hclk);
        if (sel)
        begin
            hub_rst <= 1'b1;
        end
        else
        begin
            resume <= 1'b1;
        end
        @(posedge hclk);
        hub_rst <= 1'b0;
        resume <= 1'b0;
    endtask

    task automatic tend(input string name);
        $display("test %0s done", name);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        summarize();
    end

    // main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = RHP_HSIZE_WORD;
        hwdata = 32'h0;
        {attach, low_speed, resume, hub_rst} = 4'h0;
        mismatches = 0;
        num_checks = 0;
        ncmd = 0;
        cmds = '{32'h0000_0010, 32'h0000_0002, 32'h0000_0004};
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, unmapped offset
        rdc(RHP_OFS_PORT, 32'h0000_0100);
        rdc(RHP_OFS_IRQ_STAT, 32'h0000_0000);
        rdc(RHP_OFS_IRQ_MASK, 32'h0000_0000);
        rdc(RHP_OFS_DESC_B, 32'h0000_0000);
        rdc(8'h10, 32'h0000_0000);
        tend("reset");
        // connect, reserved writes, clear
        attach <= 1'b1;
        idle(3);
        rdc(RHP_OFS_PORT, 32'h0001_0101);
        wr(RHP_OFS_PORT, 32'hFFE0_FC00);
        rdc(RHP_OFS_PORT, 32'h0001_0101);
        wr(RHP_OFS_PORT, 32'h0001_0000);
        rdc(RHP_OFS_PORT, 32'h0000_0101);
        tend("connect");
        // low speed and power bits
        low_speed <= 1'b1;
        idle(3);
        rdc(RHP_OFS_PORT, 32'h0000_0301);
        wr(RHP_OFS_PORT, 32'h0000_0000);
        rdc(RHP_OFS_PORT, 32'h0000_0301);
        wr(RHP_OFS_PORT, 32'h0000_0200);
        rdc(RHP_OFS_PORT, 32'h0000_0201);
        wr(RHP_OFS_PORT, 32'h0000_0100);
        rdc(RHP_OFS_PORT, 32'h0000_0301);
        tend("power");
        // port reset, change flags and interrupt
        wr(RHP_OFS_IRQ_STAT, 32'h0000_000F);
        wr(RHP_OFS_PORT, 32'h0000_0010);
        idle(15);
        check(ncmd, 32'h1);
        rdc(RHP_OFS_PORT, 32'h0012_0303);
        rdc(RHP_OFS_IRQ_STAT, 32'h0000_000A);
        check({31'h0, irq}, 32'h0);
        wr(RHP_OFS_IRQ_MASK, 32'h0000_0002);
        idle(2);
        check({31'h0, irq}, 32'h1);
        wr(RHP_OFS_IRQ_STAT, 32'h0000_0002);
        idle(2);
        check({31'h0, irq}, 32'h0);
        wr(RHP_OFS_PORT, 32'h0012_0000);
        rdc(RHP_OFS_PORT, 32'h0000_0303);
        tend("port_reset");
        // suspend entry, then resume with synchronisation delay
        wr(RHP_OFS_PORT, 32'h0000_0004);
        idle(3);
        rdc(RHP_OFS_PORT, 32'h0004_0307);
        wr(RHP_OFS_PORT, 32'h0004_0000);
        rdc(RHP_OFS_PORT, 32'h0000_0307);
        pulse(1'b0);
        rdc(RHP_OFS_PORT, 32'h0000_0303);
        idle(40);
        rdc(RHP_OFS_PORT, 32'h0004_0303);
        wr(RHP_OFS_PORT, 32'h0004_0000);
        check(ncmd, 32'h2);
        tend("suspend");
        // set commands while disconnected
        attach <= 1'b0;
        idle(3);
        rdc(RHP_OFS_PORT, 32'h0003_0100);
        wr(RHP_OFS_PORT, 32'h0003_0000);
        foreach (cmds[i])
        begin
            wr(RHP_OFS_PORT, cmds[i]);
            idle(2);
            rdc(RHP_OFS_PORT, 32'h0001_0100);
            wr(RHP_OFS_PORT, 32'h0001_0000);
        end
        check(ncmd, 32'h2);
        tend("disconnected");
        // nonremovable device reported only by hub reset
        wr(RHP_OFS_DESC_B, 32'h0000_0004);
        rdc(RHP_OFS_DESC_B, 32'h0000_0004);
        attach <= 1'b1;
        idle(3);
        rdc(RHP_OFS_PORT, 32'h0000_0301);
        pulse(1'b1);
        idle(3);
        rdc(RHP_OFS_PORT, 32'h0001_0301);
        check({31'h0, hresp}, 32'h0);
        check({31'h0, hreadyout}, 32'h1);
        tend("nonremovable");
        // set enable while connected, then a refused byte-size write
        wr(RHP_OFS_PORT, 32'h0000_0002);
        idle(2);
        rdc(RHP_OFS_PORT, 32'h0003_0303);
        check(ncmd, 32'h3);
        hsize <= 3'h0;
        wr(RHP_OFS_IRQ_MASK, 32'h0000_000F);
        hsize <= RHP_HSIZE_WORD;
        rdc(RHP_OFS_IRQ_MASK, 32'h0000_0002);
        tend("enable_size");
        summarize();
    end
endmodule
